/* File: include/alarm_regs_pkg.sv */
// register map, field layouts and reset values of the alarm, clear and power-down bank
package alarm_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_INPUTS = 5;
    localparam int NUM_DACS = 16;
    localparam int CODE_W = 12;
    localparam int TEMP_W = 12;
    localparam int INPUT_DB_W = 7;
    localparam int TEMP_DB_W = 5;
    localparam int LIMIT_NIB_W = 4;
    localparam int ALARM_W = NUM_INPUTS + 1;

    // register byte addresses
    localparam logic [7:0] ADDR_TEMP_LOW_LIMIT_HIGH = 8'h97;
    localparam logic [7:0] ADDR_INPUT_DEADBAND_BASE = 8'ha0;
    localparam logic [7:0] ADDR_TEMP_DEADBAND = 8'ha5;
    localparam logic [7:0] ADDR_DAC_CLEAR_LOW = 8'hb0;
    localparam logic [7:0] ADDR_DAC_CLEAR_HIGH = 8'hb1;
    localparam logic [7:0] ADDR_POWER_DOWN_LOW = 8'hb2;
    localparam logic [7:0] ADDR_POWER_DOWN_HIGH = 8'hb3;
    localparam logic [7:0] ADDR_TEMP_LOW_LIMIT_LOW = 8'h96;
    localparam logic [7:0] ADDR_TEMP_HIGH_LIMIT_LOW = 8'h94;
    localparam logic [7:0] ADDR_TEMP_HIGH_LIMIT_HIGH = 8'h95;
    localparam logic [7:0] ADDR_INPUT_LIMIT_BASE = 8'h80;
    localparam logic [7:0] ADDR_ALARM_STATUS = 8'hc8;
    localparam logic [7:0] ADDR_ALARM_MASK = 8'hc9;

    // reset values
    localparam logic [7:0] RST_TEMP_LOW_LIMIT_HIGH = 8'h08;
    localparam logic [7:0] RST_TEMP_HIGH_LIMIT_HIGH = 8'h07;
    localparam logic [7:0] RST_DEADBAND = 8'h08;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONES = 8'hff;
    localparam logic [7:0] RST_INPUT_HIGH_LIMIT_HIGH = 8'h0f;

    // per-input limit block: four bytes per input
    localparam int LIMIT_BYTES = 4;
    localparam logic [1:0] LIM_HI_LOW = 2'h0;
    localparam logic [1:0] LIM_HI_HIGH = 2'h1;
    localparam logic [1:0] LIM_LO_LOW = 2'h2;
    localparam logic [1:0] LIM_LO_HIGH = 2'h3;

    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

/* File: hw/alarm_hysteresis_dac_clear_regs.sv */
// alarm limits, hysteresis, dac clear and power-down register bank with alarm logic
// Functional notes
// - temp lower limit high nibble, reset 8, signed
// - hysteresis registers set each alarm deadband
// - five 7-bit input deadbands from a0, reset 08
// - 5-bit temperature deadband at a5, 1 degree steps
// - reserved bits reset zero, stay read/write
// - clear bit one forces dac output clear
// - clear bit zero restores normal dac code
// - clear register b0 holds dacs 0 to 7
// - clear register b1 holds dacs 8 to 15
// - power-down register b2 holds dacs 0 to 7
// - power-down bits reset to zero, functions off
// - writing one activates, zero deactivates function
// - inactive dac power control holds clamp mode
// - out-of-window value sets channel alarm flag
// - upper not above lower means permanent alarm
`timescale 1ns/1ps
`default_nettype none
module alarm_hysteresis_dac_clear_regs
    import alarm_regs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic [NUM_INPUTS*CODE_W-1:0] input_codes,
    input wire logic [TEMP_W-1:0] temp_code,
    input wire logic sample_valid,
    input wire logic [NUM_DACS*CODE_W-1:0] dac_codes,
    output logic [NUM_DACS*CODE_W-1:0] dac_out_codes,
    output logic [NUM_DACS-1:0] dac_clamp,
    output logic [ALARM_W-1:0] channel_alarm_flag,
    output logic irq
);
    logic [DATA_W-1:0] temp_low_limit_low;
    logic [DATA_W-1:0] temp_low_limit_high;
    logic [DATA_W-1:0] temp_high_limit_low;
    logic [DATA_W-1:0] temp_high_limit_high;
    logic [DATA_W-1:0] input_limits [NUM_INPUTS*LIMIT_BYTES];
    logic [DATA_W-1:0] analog_input_hysteresis [NUM_INPUTS];
    logic [DATA_W-1:0] temperature_hysteresis;
    logic [DATA_W-1:0] dac_clear_low_group;
    logic [DATA_W-1:0] dac_clear_high_group;
    logic [DATA_W-1:0] power_down_low_group;
    logic [DATA_W-1:0] power_down_high_group;
    logic [DATA_W-1:0] alarm_mask;
    logic [ALARM_W-1:0] alarm_status;
    logic [ALARM_W-1:0] out_of_range;
    logic [ALARM_W-1:0] next_out_of_range;
    logic [ALARM_W-1:0] clear_status;
    logic access_done;
    logic wr_en;
    logic [DATA_W-1:0] next_readdata;
    logic [NUM_DACS-1:0] dac_force_zero_bit;
    logic [NUM_DACS-1:0] dac_power_control;

    // one wait cycle per access: answer at the second edge of the request
    assign waitrequest = (read | write) & ~access_done;
    assign wr_en = write & access_done;

    // per-register write strobes, taken at the edge that sees waitrequest low
    logic wr_temp_high_low;
    logic wr_temp_high_high;
    logic wr_temp_low_low;
    logic wr_temp_low_high;
    logic wr_temp_db;
    logic wr_clear_low;
    logic wr_clear_high;
    logic wr_power_low;
    logic wr_power_high;
    logic wr_mask;
    logic wr_status;
    assign wr_temp_high_low = wr_en && (address == ADDR_TEMP_HIGH_LIMIT_LOW);
    assign wr_temp_high_high = wr_en && (address == ADDR_TEMP_HIGH_LIMIT_HIGH);
    assign wr_temp_low_low = wr_en && (address == ADDR_TEMP_LOW_LIMIT_LOW);
    assign wr_temp_low_high = wr_en && (address == ADDR_TEMP_LOW_LIMIT_HIGH);
    assign wr_temp_db = wr_en && (address == ADDR_TEMP_DEADBAND);
    assign wr_clear_low = wr_en && (address == ADDR_DAC_CLEAR_LOW);
    assign wr_clear_high = wr_en && (address == ADDR_DAC_CLEAR_HIGH);
    assign wr_power_low = wr_en && (address == ADDR_POWER_DOWN_LOW);
    assign wr_power_high = wr_en && (address == ADDR_POWER_DOWN_HIGH);
    assign wr_mask = wr_en && (address == ADDR_ALARM_MASK);
    assign wr_status = wr_en && (address == ADDR_ALARM_STATUS);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            access_done <= 1'b0;
        end else begin
            access_done <= (read | write) & ~access_done;
        end
    end

    function automatic logic in_input_limits(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_INPUT_LIMIT_BASE) &&
               (a < ADDR_INPUT_LIMIT_BASE + ADDR_W'(NUM_INPUTS*LIMIT_BYTES));
    endfunction

    function automatic logic in_input_deadband(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_INPUT_DEADBAND_BASE) &&
               (a < ADDR_INPUT_DEADBAND_BASE + ADDR_W'(NUM_INPUTS));
    endfunction

    // input limit bytes, high halves reset to all ones upper limit
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_INPUTS*LIMIT_BYTES; i++) begin
                unique case (2'(i % LIMIT_BYTES))
                    LIM_HI_LOW: input_limits[i] <= RST_ONES;
                    LIM_HI_HIGH: input_limits[i] <= RST_INPUT_HIGH_LIMIT_HIGH;
                    LIM_LO_LOW: input_limits[i] <= RST_ZERO;
                    LIM_LO_HIGH: input_limits[i] <= RST_ZERO;
                endcase
            end
        end else if (wr_en && in_input_limits(address)) begin
            input_limits[5'(address - ADDR_INPUT_LIMIT_BASE)] <= writedata;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            temp_high_limit_low <= RST_ONES;
            temp_high_limit_high <= RST_TEMP_HIGH_LIMIT_HIGH;
            temp_low_limit_low <= RST_ZERO;
            temp_low_limit_high <= RST_TEMP_LOW_LIMIT_HIGH;
        end else begin
            if (wr_temp_high_low) begin
                temp_high_limit_low <= writedata;
            end
            if (wr_temp_high_high) begin
                temp_high_limit_high <= writedata;
            end
            if (wr_temp_low_low) begin
                temp_low_limit_low <= writedata;
            end
            if (wr_temp_low_high) begin
                temp_low_limit_high <= writedata;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                analog_input_hysteresis[i] <= RST_DEADBAND;
            end
            temperature_hysteresis <= RST_DEADBAND;
        end else if (wr_en) begin
            if (in_input_deadband(address)) begin
                analog_input_hysteresis[3'(address - ADDR_INPUT_DEADBAND_BASE)] <= writedata;
            end
            if (wr_temp_db) begin
                temperature_hysteresis <= writedata;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dac_clear_low_group <= RST_ZERO;
            dac_clear_high_group <= RST_ZERO;
            power_down_low_group <= RST_ZERO;
            power_down_high_group <= RST_ZERO;
        end else begin
            if (wr_clear_low) begin
                dac_clear_low_group <= writedata;
            end
            if (wr_clear_high) begin
                dac_clear_high_group <= writedata;
            end
            if (wr_power_low) begin
                power_down_low_group <= writedata;
            end
            if (wr_power_high) begin
                power_down_high_group <= writedata;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alarm_mask <= RST_ZERO;
        end else if (wr_mask) begin
            alarm_mask <= writedata;
        end
    end

    // dac output path: clear forces zero code, inactive power control clamps
    assign dac_force_zero_bit = {dac_clear_high_group, dac_clear_low_group};
    assign dac_power_control = {power_down_high_group, power_down_low_group};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dac_out_codes <= '0;
        end else begin
            for (int d = 0; d < NUM_DACS; d++) begin
                if (dac_force_zero_bit[d]) begin
                    dac_out_codes[d*CODE_W +: CODE_W] <= '0;
                end else begin
                    dac_out_codes[d*CODE_W +: CODE_W] <= dac_codes[d*CODE_W +: CODE_W];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dac_clamp <= '1;
        end else begin
            dac_clamp <= ~dac_power_control;
        end
    end

    // window comparison with hysteresis, one per monitored channel
    function automatic logic window_step(
        input logic signed [CODE_W+1:0] value,
        input logic signed [CODE_W+1:0] upper,
        input logic signed [CODE_W+1:0] lower,
        input logic signed [CODE_W+1:0] band,
        input logic was_out
    );
        logic outside;
        logic inside_margin;
        outside = (value > upper) || (value < lower);
        inside_margin = (value <= upper - band) && (value >= lower + band);
        if (upper <= lower) return 1'b1;
        if (outside) return 1'b1;
        if (was_out) return ~inside_margin;
        return 1'b0;
    endfunction

    always_comb begin
        next_out_of_range = out_of_range;
        for (int c = 0; c < NUM_INPUTS; c++) begin
            next_out_of_range[c] = window_step(
                {2'b00, input_codes[c*CODE_W +: CODE_W]},
                {2'b00, input_limits[c*LIMIT_BYTES+1][LIMIT_NIB_W-1:0],
                    input_limits[c*LIMIT_BYTES]},
                {2'b00, input_limits[c*LIMIT_BYTES+3][LIMIT_NIB_W-1:0],
                    input_limits[c*LIMIT_BYTES+2]},
                {7'h00, analog_input_hysteresis[c][INPUT_DB_W-1:0]},
                out_of_range[c]);
        end
        next_out_of_range[NUM_INPUTS] = window_step(
            {{2{temp_code[TEMP_W-1]}}, temp_code},
            {{3{temp_high_limit_high[LIMIT_NIB_W-1]}},
                temp_high_limit_high[LIMIT_NIB_W-2:0], temp_high_limit_low},
            {{3{temp_low_limit_high[LIMIT_NIB_W-1]}},
                temp_low_limit_high[LIMIT_NIB_W-2:0], temp_low_limit_low},
            {9'h000, temperature_hysteresis[TEMP_DB_W-1:0]},
            out_of_range[NUM_INPUTS]);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            out_of_range <= '0;
        end else if (sample_valid) begin
            out_of_range <= next_out_of_range;
        end
    end

    // sticky status: write one to clear, a new event wins over the clear
    assign clear_status = wr_status ? writedata[ALARM_W-1:0] : '0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alarm_status <= '0;
        end else begin
            alarm_status <= (alarm_status & ~clear_status) | out_of_range;
        end
    end

    assign channel_alarm_flag = alarm_status;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(alarm_status & alarm_mask[ALARM_W-1:0]);
        end
    end

    always_comb begin
        next_readdata = UNMAPPED_READ;
        if (in_input_limits(address)) begin
            next_readdata = input_limits[5'(address - ADDR_INPUT_LIMIT_BASE)];
        end else if (in_input_deadband(address)) begin
            next_readdata = analog_input_hysteresis[3'(address - ADDR_INPUT_DEADBAND_BASE)];
        end else begin
            unique case (address)
                ADDR_TEMP_HIGH_LIMIT_LOW: begin
                    next_readdata = temp_high_limit_low;
                end
                ADDR_TEMP_HIGH_LIMIT_HIGH: begin
                    next_readdata = temp_high_limit_high;
                end
                ADDR_TEMP_LOW_LIMIT_LOW: begin
                    next_readdata = temp_low_limit_low;
                end
                ADDR_TEMP_LOW_LIMIT_HIGH: begin
                    next_readdata = temp_low_limit_high;
                end
                ADDR_TEMP_DEADBAND: begin
                    next_readdata = temperature_hysteresis;
                end
                ADDR_DAC_CLEAR_LOW: begin
                    next_readdata = dac_clear_low_group;
                end
                ADDR_DAC_CLEAR_HIGH: begin
                    next_readdata = dac_clear_high_group;
                end
                ADDR_POWER_DOWN_LOW: begin
                    next_readdata = power_down_low_group;
                end
                ADDR_POWER_DOWN_HIGH: begin
                    next_readdata = power_down_high_group;
                end
                ADDR_ALARM_STATUS: begin
                    next_readdata = {{(DATA_W-ALARM_W){1'b0}}, alarm_status};
                end
                ADDR_ALARM_MASK: begin
                    next_readdata = alarm_mask;
                end
                default: next_readdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= '0;
        end else if (read && !access_done) begin
            readdata <= next_readdata;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/alarm_regs_checker.sv */
// assertion checker for the alarm, clear and power-down register bank
`timescale 1ns/1ps
`default_nettype none
module alarm_regs_checker
    import alarm_regs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic waitrequest,
    input wire logic [NUM_DACS*CODE_W-1:0] dac_codes,
    input wire logic [NUM_DACS*CODE_W-1:0] dac_out_codes,
    input wire logic [NUM_DACS-1:0] dac_clamp,
    input wire logic [ALARM_W-1:0] channel_alarm_flag,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic req;
    logic wr_done;
    assign req = read | write;
    assign wr_done = write & ~waitrequest;

    chk_first_wait: assert property ($rose(req) |-> waitrequest)
        else $error("new request not held off");
    chk_single_wait: assert property (req && waitrequest ##1 req |-> !waitrequest)
        else $error("more than one wait state");
    chk_idle_ready: assert property (!req |-> !waitrequest)
        else $error("waitrequest without request");
    chk_clear_low: assert property (wr_done && address == ADDR_DAC_CLEAR_LOW && writedata[0]
        |=> ##1 dac_out_codes[11:0] == 12'h000) else $error("dac 0 not cleared");
    chk_clear_high: assert property (wr_done && address == ADDR_DAC_CLEAR_HIGH && writedata[7]
        |=> ##1 dac_out_codes[191:180] == 12'h000) else $error("dac 15 not cleared");
    chk_clear_restore: assert property (wr_done && address == ADDR_DAC_CLEAR_LOW
        && !writedata[0] |=> ##1 dac_out_codes[11:0] == $past(dac_codes[11:0]))
        else $error("dac 0 not restored");
    chk_power_on: assert property (wr_done && address == ADDR_POWER_DOWN_LOW && writedata[7]
        |=> ##1 !dac_clamp[7]) else $error("dac 7 still clamped");
    chk_power_off: assert property (wr_done && address == ADDR_POWER_DOWN_LOW && !writedata[0]
        |=> ##1 dac_clamp[0]) else $error("dac 0 not clamped");
    chk_reset_clamp: assert property ($rose(rst_b) |-> dac_clamp == 16'hffff)
        else $error("clamps wrong after reset");
    chk_irq_cause: assert property (!(|channel_alarm_flag) |=> !irq)
        else $error("irq without alarm");
    chk_flag_sticky: assert property (channel_alarm_flag[0]
        && !(wr_done && address == ADDR_ALARM_STATUS) |=> channel_alarm_flag[0])
        else $error("alarm flag lost");
    cover property (wr_done && address == ADDR_DAC_CLEAR_LOW);
    cover property ($rose(channel_alarm_flag[0]));
    cover property ($rose(irq));
endmodule
bind alarm_hysteresis_dac_clear_regs alarm_regs_checker chk_u (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .dac_codes(dac_codes), .dac_out_codes(dac_out_codes), .dac_clamp(dac_clamp),
    .channel_alarm_flag(channel_alarm_flag), .irq(irq));
`default_nettype wire

/* File: testbench/tb_alarm_hysteresis_dac_clear_regs.sv */
// self-checking bench for the alarm, clear and power-down register bank
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_hysteresis_dac_clear_regs;
    import alarm_regs_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] writedata = 8'h00;
    logic [7:0] readdata;
    logic waitrequest;
    logic [59:0] input_codes = {5{12'h800}};
    logic [11:0] temp_code = 12'h000;
    logic sample_valid = 1'b1;
    logic [191:0] dac_codes;
    logic [191:0] dac_out_codes;
    logic [191:0] expect_dac;
    logic [15:0] dac_clamp;
    logic [5:0] channel_alarm_flag;
    logic irq;
    logic [7:0] q;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] reg_addr [11] = '{8'h97, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5,
        8'hb0, 8'hb1, 8'hb2, 8'hb3};
    logic [7:0] reg_rst [11] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08,
        8'h00, 8'h00, 8'h00, 8'h00};

    always #4 clock = ~clock;

    alarm_hysteresis_dac_clear_regs dut_u (
        .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .input_codes(input_codes), .temp_code(temp_code), .sample_valid(sample_valid),
        .dac_codes(dac_codes), .dac_out_codes(dac_out_codes), .dac_clamp(dac_clamp),
        .channel_alarm_flag(channel_alarm_flag), .irq(irq));

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end

    task automatic compare_value(input logic [191:0] got, input logic [191:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // one avalon transfer, request held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 20) begin
            errors++;
            complete_run();
        end
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b1, a, 8'h00);
        compare_value(192'(q), 192'(exp));
    endtask

    // alarm path and dac outputs take up to three edges to follow
    task automatic settle;
        repeat (4) @(posedge clock);
    endtask

    initial begin
        for (int d = 0; d < 16; d++) dac_codes[d*12+:12] = 12'h100 + 12'(d);
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        compare_value(192'(dac_clamp), 192'(16'hffff));
        foreach (reg_addr[i]) expect_reg(reg_addr[i], reg_rst[i]);
        foreach (reg_addr[i]) begin
            wr(reg_addr[i], 8'hff);
            expect_reg(reg_addr[i], 8'hff);
        end
        foreach (reg_addr[i]) wr(reg_addr[i], reg_rst[i]);
        wr(8'hd0, 8'h5a);
        expect_reg(8'hd0, 8'h00);
        wr(ADDR_DAC_CLEAR_LOW, 8'h01);
        wr(ADDR_DAC_CLEAR_HIGH, 8'h80);
        settle();
        expect_dac = dac_codes;
        expect_dac[11:0] = 12'h000;
        expect_dac[191:180] = 12'h000;
        compare_value(dac_out_codes, expect_dac);
        wr(ADDR_DAC_CLEAR_LOW, 8'h00);
        wr(ADDR_DAC_CLEAR_HIGH, 8'h00);
        settle();
        compare_value(dac_out_codes, dac_codes);
        wr(ADDR_POWER_DOWN_LOW, 8'h81);
        wr(ADDR_POWER_DOWN_HIGH, 8'h01);
        settle();
        compare_value(192'(dac_clamp), 192'(16'hfe7e));
        wr(ADDR_POWER_DOWN_LOW, 8'h00);
        wr(ADDR_POWER_DOWN_HIGH, 8'h00);
        settle();
        compare_value(192'(dac_clamp), 192'(16'hffff));
        wr(8'h83, 8'h01);
        input_codes[11:0] <= 12'h0ff;
        settle();
        compare_value(192'(channel_alarm_flag), 192'(6'h01));
        wr(ADDR_ALARM_MASK, 8'h01);
        settle();
        compare_value(192'(irq), 192'(1'b1));
        input_codes[11:0] <= 12'h104;
        wr(ADDR_ALARM_STATUS, 8'h01);
        settle();
        expect_reg(ADDR_ALARM_STATUS, 8'h01);
        input_codes[11:0] <= 12'h108;
        settle();
        wr(ADDR_ALARM_STATUS, 8'h01);
        settle();
        expect_reg(ADDR_ALARM_STATUS, 8'h00);
        compare_value(192'(irq), 192'(1'b0));
        wr(8'h80, 8'h00);
        wr(8'h81, 8'h00);
        settle();
        expect_reg(ADDR_ALARM_STATUS, 8'h01);
        wr(ADDR_ALARM_MASK, 8'h00);
        settle();
        compare_value(192'(irq), 192'(1'b0));
        complete_run();
    end
endmodule
`default_nettype wire
